// [verilog/rtc_pkg.sv]
/*
  Package for the timekeeping core: register indices, field positions,
  reset values, prescaler constants and the packed time carrier.
  Assumes a 32-bit AXI4-Lite register bus, one aligned word per register.
*/
`default_nettype none
package rtc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [2:0] RTC_IDX_SEC = 3'h0;
  localparam logic [2:0] RTC_IDX_MIN = 3'h1;
  localparam logic [2:0] RTC_IDX_HOUR = 3'h2;
  localparam logic [2:0] RTC_IDX_WDAY = 3'h3;
  localparam logic [2:0] RTC_IDX_DATE = 3'h4;
  localparam logic [2:0] RTC_IDX_MONTH = 3'h5;
  localparam logic [2:0] RTC_IDX_YEAR = 3'h6;
  localparam logic [2:0] RTC_IDX_TRIM = 3'h7;

  // Field positions
  localparam int RTC_HOUR_MODE_BIT = 7;
  localparam int RTC_HOUR_PM_BIT = 5;
  localparam int RTC_TRIM_TEST_BIT = 7;

  // Reset values of the counters and the trim register
  localparam logic [6:0] RTC_RST_SEC = 7'h00;
  localparam logic [6:0] RTC_RST_MIN = 7'h00;
  localparam logic [5:0] RTC_RST_HOUR = 6'h12;
  localparam logic [2:0] RTC_RST_WDAY = 3'h0;
  localparam logic [5:0] RTC_RST_DATE = 6'h01;
  localparam logic [4:0] RTC_RST_MONTH = 5'h01;
  localparam logic [7:0] RTC_RST_YEAR = 8'h01;
  localparam logic [7:0] RTC_RST_TRIM = 8'h00;

  // Wrap points in BCD
  localparam logic [7:0] RTC_SEC_MAX = 8'h59;
  localparam logic [7:0] RTC_MIN_MAX = 8'h59;
  localparam logic [7:0] RTC_H24_MAX = 8'h23;
  localparam logic [7:0] RTC_H12_NOON = 8'h12;
  localparam logic [7:0] RTC_H12_ELEVEN = 8'h11;
  localparam logic [2:0] RTC_WDAY_MAX = 3'h6;
  localparam logic [7:0] RTC_MONTH_MAX = 8'h12;
  localparam logic [7:0] RTC_YEAR_MAX = 8'h99;

  // Oscillator edges per second and index of the last second of the trim period
  localparam int RTC_OSC_PER_SEC = 32768;
  localparam logic [3:0] RTC_TRIM_LAST_SEC = 4'h9;

  // AXI responses
  localparam logic [1:0] RTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RTC_RESP_SLVERR = 2'h2;

  typedef logic [31:0] rtc_word_t;
  typedef logic [3:0] rtc_strb_t;
  typedef logic [1:0] rtc_resp_t;

  typedef struct packed {
    logic [6:0] sec;
    logic [6:0] min;
    logic mode24;
    logic [5:0] hour;
    logic [2:0] wday;
    logic [5:0] date;
    logic [4:0] month;
    logic [7:0] year;
  } rtc_time_s;

endpackage
`default_nettype wire

// [verilog/rtc_core.sv]
/*
  Timekeeping core: BCD seconds, minutes, hours (12/24 h), weekday,
  date, month and year with leap years, plus a rate trim, all behind
  an AXI4-Lite slave. The 32.768 kHz oscillator arrives as a pin and
  is synchronised here; its untrimmed level is driven back out.
  Assumes a master that keeps to AXI4-Lite handshakes.
*/
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rtc_core #(
  parameter int OSC_PER_SEC = rtc_pkg::RTC_OSC_PER_SEC
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Oscillator pin and its untrimmed copy
  input wire logic osc_pin,
  output logic clock_output_pin,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire rtc_pkg::rtc_word_t awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire rtc_pkg::rtc_word_t wdata,
  input wire rtc_pkg::rtc_strb_t wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output rtc_pkg::rtc_resp_t bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire rtc_pkg::rtc_word_t araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output rtc_pkg::rtc_word_t rdata,
  output rtc_pkg::rtc_resp_t rresp
);
  import rtc_pkg::*;

  // BCD increment of one packed byte
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Leap test on a BCD year: tens parity decides which units divide
  function automatic logic bcd_leap(input logic [7:0] y);
    if (y[4]) begin
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
    return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  // Last date of the month in BCD
  function automatic logic [7:0] last_date(input logic [4:0] mo, input logic [7:0] y);
    unique case (mo)
      5'h02: last_date = bcd_leap(y) ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: last_date = 8'h30;
      default: last_date = 8'h31;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Oscillator synchroniser

  logic osc_s1, osc_s2, osc_s3, osc_rise;
  // Three stages; the first one feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else if (ce) begin
      osc_s1 <= osc_pin;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // Accepted level moves only when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_output_pin <= 1'b0;
    end else if (ce && osc_s2 == osc_s3) begin
      clock_output_pin <= osc_s3;
    end
  end

  assign osc_rise = ce && (osc_s2 == osc_s3) && osc_s3 && !clock_output_pin;

  ////////////////////////////////////////////////////////////////////
  // Register bus slave

  logic aw_held, w_held, w_lane0, do_wr, wr_ok, rd_ok;
  logic [31:0] aw_addr;
  logic [7:0] w_byte, rd_val, trim, wr_sel;
  logic [2:0] wr_idx;
  rtc_time_s t, next_t;
  assign do_wr = aw_held && w_held && !bvalid;
  assign wr_ok = (aw_addr[31:5] == 27'h0) && (aw_addr[1:0] == 2'h0);
  assign wr_idx = aw_addr[4:2];
  assign rd_ok = (araddr[31:5] == 27'h0) && (araddr[1:0] == 2'h0);

  // Address and data taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RTC_RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_held <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_byte <= wdata[7:0];
        w_lane0 <= wstrb[0];
        w_held <= 1'b1;
        wready <= 1'b0;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? RTC_RESP_OKAY : RTC_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read view; unused upper bits read as zero
  always_comb begin
    rd_val = 8'h00;
    unique case (araddr[4:2])
      RTC_IDX_SEC: rd_val = {1'b0, t.sec};
      RTC_IDX_MIN: rd_val = {1'b0, t.min};
      RTC_IDX_HOUR: rd_val = {t.mode24, 1'b0, t.hour};
      RTC_IDX_WDAY: rd_val = {5'h00, t.wday};
      RTC_IDX_DATE: rd_val = {2'h0, t.date};
      RTC_IDX_MONTH: rd_val = {3'h0, t.month};
      RTC_IDX_YEAR: rd_val = t.year;
      RTC_IDX_TRIM: rd_val = trim;
    endcase
  end

  // One read at a time, answered the cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RTC_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_ok ? {24'h0, rd_val} : 32'h0;
        rresp <= rd_ok ? RTC_RESP_OKAY : RTC_RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Per-register write strobe, byte lane 0 only
  always_comb begin
    wr_sel = 8'h00;
    if (do_wr && wr_ok && w_lane0) begin
      wr_sel[wr_idx] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Prescaler with rate trim

  logic [16:0] pre, sec_len;
  logic [3:0] decade;
  logic sec_tick;
  // Positive trim shortens every tenth second: one edge is 3.05 ppm
  assign sec_len = 17'(OSC_PER_SEC) - ((decade == RTC_TRIM_LAST_SEC) ?
                   {{10{trim[6]}}, trim[6:0]} : 17'h0);
  assign sec_tick = osc_rise && (pre == sec_len - 17'h1);

  // Seconds write restarts the second and the trim period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre <= 17'h0;
      decade <= 4'h0;
    end else if (ce) begin
      if (wr_sel[RTC_IDX_SEC]) begin
        pre <= 17'h0;
        decade <= 4'h0;
      end else if (sec_tick) begin
        pre <= 17'h0;
        decade <= (decade == RTC_TRIM_LAST_SEC) ? 4'h0 : decade + 4'h1;
      end else if (osc_rise) begin
        pre <= pre + 17'h1;
      end
    end
  end

  // Trim register; bit 7 is stored but steers nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim <= RTC_RST_TRIM;
    end else if (ce && wr_sel[RTC_IDX_TRIM]) begin
      trim <= w_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Carry chain

  logic c_min, c_hour, c_day, c_month, c_year;
  logic [7:0] h12;
  // Seconds, minutes, 24 h hours, date and month wraps each feed one increment into the next unit; 12 h hours carry from 11 PM
  always_comb begin
    next_t = t;
    c_min = 1'b0;
    c_hour = 1'b0;
    c_day = 1'b0;
    c_month = 1'b0;
    c_year = 1'b0;
    h12 = {3'h0, t.hour[4:0]};
    if (sec_tick) begin
      if ({1'b0, t.sec} == RTC_SEC_MAX) begin
        next_t.sec = 7'h00;
        c_min = 1'b1;
      end else begin
        next_t.sec = 7'(bcd_inc({1'b0, t.sec}));
      end
    end
    if (c_min) begin
      if ({1'b0, t.min} == RTC_MIN_MAX) begin
        next_t.min = 7'h00;
        c_hour = 1'b1;
      end else begin
        next_t.min = 7'(bcd_inc({1'b0, t.min}));
      end
    end
    if (c_hour) begin
      if (t.mode24) begin
        if ({2'h0, t.hour} == RTC_H24_MAX) begin
          next_t.hour = 6'h00;
          c_day = 1'b1;
        end else begin
          next_t.hour = 6'(bcd_inc({2'h0, t.hour}));
        end
      end else if (h12 == RTC_H12_NOON) begin
        next_t.hour = {t.hour[RTC_HOUR_PM_BIT], 5'h01};
      end else if (h12 == RTC_H12_ELEVEN) begin
        next_t.hour = {!t.hour[RTC_HOUR_PM_BIT], 5'h12};
        c_day = t.hour[RTC_HOUR_PM_BIT];
      end else begin
        next_t.hour = {t.hour[RTC_HOUR_PM_BIT], 5'(bcd_inc(h12))};
      end
    end
    if (c_day) begin
      next_t.wday = (t.wday == RTC_WDAY_MAX) ? 3'h0 : t.wday + 3'h1;
      if ({2'h0, t.date} == last_date(t.month, t.year)) begin
        next_t.date = 6'h01;
        c_month = 1'b1;
      end else begin
        next_t.date = 6'(bcd_inc({2'h0, t.date}));
      end
    end
    if (c_month) begin
      if ({3'h0, t.month} == RTC_MONTH_MAX) begin
        next_t.month = 5'h01;
        c_year = 1'b1;
      end else begin
        next_t.month = 5'(bcd_inc({3'h0, t.month}));
      end
    end
    if (c_year) begin
      next_t.year = (t.year == RTC_YEAR_MAX) ? 8'h00 : bcd_inc(t.year);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Time state

  // Host write of a field wins over a carry landing on it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t.sec <= RTC_RST_SEC;
      t.min <= RTC_RST_MIN;
      t.mode24 <= 1'b0;
      t.hour <= RTC_RST_HOUR;
      t.wday <= RTC_RST_WDAY;
      t.date <= RTC_RST_DATE;
      t.month <= RTC_RST_MONTH;
      t.year <= RTC_RST_YEAR;
    end else if (ce) begin
      t <= next_t;
      if (wr_sel[RTC_IDX_SEC]) begin
        t.sec <= w_byte[6:0];
      end
      if (wr_sel[RTC_IDX_MIN]) begin
        t.min <= w_byte[6:0];
      end
      if (wr_sel[RTC_IDX_HOUR]) begin
        t.mode24 <= w_byte[RTC_HOUR_MODE_BIT];
        t.hour <= w_byte[5:0];
      end
      if (wr_sel[RTC_IDX_WDAY]) begin
        t.wday <= w_byte[2:0];
      end
      if (wr_sel[RTC_IDX_DATE]) begin
        t.date <= w_byte[5:0];
      end
      if (wr_sel[RTC_IDX_MONTH]) begin
        t.month <= w_byte[4:0];
      end
      if (wr_sel[RTC_IDX_YEAR]) begin
        t.year <= w_byte;
      end
    end
  end

endmodule
`default_nettype wire

// [verification/rtc_osc_model.sv]
/*
  Oscillator stand-in for the timekeeping core.
  Assumes the bench clock; each level lasts HALF clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_model #(
  parameter int HALF = 5
) (
  // Clock
  input wire logic aclk,
  // Oscillator level
  output logic osc_pin
);
  int cnt = 0;
  initial osc_pin = 1'b0;
  // Runs free; slow enough for the three-flop synchroniser
  always @(posedge aclk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      osc_pin <= ~osc_pin;
    end
  end
endmodule
`default_nettype wire

// [verification/rtc_core_sva.sv]
/*
  Port assertions for the timekeeping core.
  Assumes one clock domain and a master offering AW and W together.
*/
`timescale 1ns/1ps
`default_nettype none
module rtc_core_sva (
  // Clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Oscillator
  input wire logic osc_pin,
  input wire logic clock_output_pin,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire rtc_pkg::rtc_word_t awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire rtc_pkg::rtc_resp_t bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire rtc_pkg::rtc_word_t araddr,
  input wire logic rvalid,
  input wire rtc_pkg::rtc_word_t rdata
);
  import rtc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////
  // Write answers come two cycles after the take, read answers one cycle after
  chk_b_follows: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  chk_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  chk_wr_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while busy");
  chk_r_follows: assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h0)
    else $error("read answer bad");
  chk_bad_addr: assert property (awvalid && awready && wvalid && wready && awaddr > 32'h1f
    |-> ##2 bvalid && bresp == RTC_RESP_SLVERR) else $error("unmapped write accepted");
  // Read values stay inside their BCD ranges
  chk_sec_bcd: assert property (arvalid && arready && araddr == 32'h0 |=>
    rdata[3:0] <= 4'h9 && rdata[7:4] <= 4'h5) else $error("seconds out of range");
  chk_min_bcd: assert property (arvalid && arready && araddr == 32'h4 |=>
    rdata[3:0] <= 4'h9 && rdata[7:4] <= 4'h5) else $error("minutes out of range");
  chk_wday_range: assert property (arvalid && arready && araddr == 32'hc |=>
    rdata[7:0] <= 8'h06) else $error("weekday out of range");
  chk_month_range: assert property (arvalid && arready && araddr == 32'h14 |=>
    rdata[7:0] inside {[8'h01:8'h12]} && rdata[3:0] <= 4'h9) else $error("month bad");
  // Output pin follows the raw oscillator; stale stages after a freeze are excused
  chk_out_untrimmed: assert property ($rose(clock_output_pin) && $past(ce) && $past(ce, 2)
    && $past(ce, 3) |-> $past(osc_pin, 3)) else $error("clock output not raw");
endmodule
bind rtc_core rtc_core_sva u_rtc_core_sva (
  .aclk, .aresetn, .ce, .osc_pin, .clock_output_pin, .awvalid, .awready, .awaddr,
  .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
  .rvalid, .rdata
);
`default_nettype wire

// [verification/tb_rtc_core.sv]
/*
  Self-checking bench: calendar carries, prescaler clear, unmapped
  access, trim register and reset values.
  Assumes the package, the core, the oscillator model and the checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, sn) begin cmp_count++; if ((sn) !== (ex)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, sn); end end
module tb_rtc_core;
  import rtc_pkg::*;
  typedef struct packed {
    logic [7:0] h, wd, d, mo, y, eh, ewd, ed, emo, ey;
  } rtc_row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, osc_pin, clock_output_pin;
  logic ce = 1'b1;
  rtc_strb_t wstrb = 4'h1;
  rtc_word_t awaddr = '0, wdata = '0, araddr = '0, rdata, rd_v;
  rtc_resp_t bresp, rresp, resp;
  int n_fail = 0;
  int cmp_count = 0;
  logic [7:0] vals [7];
  logic [7:0] ev [8];
  // Loaded time just before a carry, then expected time one second on
  rtc_row_s rows [10] = '{
    80'ha3_06_31_12_99_80_00_01_01_00,
    80'ha3_05_31_01_20_80_06_01_02_20,
    80'ha3_02_30_04_21_80_03_01_05_21,
    80'ha3_01_28_02_04_80_02_29_02_04,
    80'ha3_01_29_02_04_80_02_01_03_04,
    80'ha3_01_28_02_03_80_02_01_03_03,
    80'h11_03_15_06_10_32_03_15_06_10,
    80'h31_03_15_06_10_12_04_16_06_10,
    80'h12_03_15_06_10_01_03_15_06_10,
    80'h99_03_15_06_10_a0_03_15_06_10
  };
  rtc_osc_model #(.HALF(5)) u_rtc_osc_model (.aclk, .osc_pin);
  // Short second: eight oscillator edges
  rtc_core #(.OSC_PER_SEC(8)) u_rtc_core (
    .aclk, .aresetn, .ce, .osc_pin, .clock_output_pin,
    .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot(3'h0), .rvalid, .rready, .rdata, .rresp
  );
  always #2.5 aclk = ~aclk;
  ////////////////////////
  // Write: AW and W offered together, each dropped when taken
  task automatic wr(input rtc_word_t a, input logic [7:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= {24'h0, d};
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // bready rises with bvalid, so the response is taken without waiting
    @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input rtc_word_t a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////
  // Watchdog
  initial begin
    #30000;
    n_fail++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      vals = '{rows[i].h, rows[i].wd, rows[i].d, rows[i].mo, rows[i].y, 8'h59, 8'h59};
      // Hours first, seconds last so the prescaler restarts
      for (int j = 0; j < 7; j++) begin
        wr(rtc_word_t'(j < 5 ? 4 * j + 8 : 24 - 4 * j), vals[j]);
      end
      repeat (100) @(posedge aclk);
      ev = '{8'h00, 8'h00, rows[i].eh, rows[i].ewd, rows[i].ed, rows[i].emo, rows[i].ey, 8'h00};
      for (int j = 0; j < 7; j++) begin
        rd(rtc_word_t'(4 * j));
        `CHK("time", {24'h0, ev[j]}, rd_v)
      end
    end
    // Rewrite before the tick must postpone it
    wr(32'h0, 8'h30);
    repeat (50) @(posedge aclk);
    wr(32'h0, 8'h30);
    repeat (50) @(posedge aclk);
    rd(32'h0);
    `CHK("sec held", 32'h30, rd_v)
    repeat (50) @(posedge aclk);
    rd(32'h0);
    `CHK("sec tick", 32'h31, rd_v)
    // Low enable freezes the second; a write with lane 0 off changes nothing
    ce <= 1'b0;
    repeat (200) @(posedge aclk);
    ce <= 1'b1;
    wstrb <= 4'h0;
    wr(32'h0, 8'h45);
    wstrb <= 4'h1;
    `CHK("bresp lane", RTC_RESP_OKAY, resp)
    rd(32'h0);
    `CHK("sec frozen", 32'h31, rd_v)
    // Unmapped place
    wr(32'h20, 8'h11);
    `CHK("bresp", RTC_RESP_SLVERR, resp)
    rd(32'h20);
    `CHK("rresp", RTC_RESP_SLVERR, resp)
    `CHK("rdata", 32'h0, rd_v)
    // Trim field, test bit kept zero
    wr(32'h1c, 8'h05);
    rd(32'h1c);
    `CHK("trim", 32'h05, rd_v)
    // Tenth second after a seconds write lasts eight minus five edges
    wr(32'h0, 8'h00);
    repeat (767) @(posedge aclk);
    rd(32'h0);
    `CHK("trimmed tick", 32'h10, rd_v)
    wr(32'h1c, 8'h00);
    // Second reset mid-run, then reset values
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    ev = '{8'h00, 8'h00, 8'h12, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    for (int j = 0; j < 8; j++) begin
      rd(rtc_word_t'(4 * j));
      `CHK("reset value", {24'h0, ev[j]}, rd_v)
    end
    end_sim();
  end
endmodule
`default_nettype wire
